// [design/rosel_consts.vh]
// register map, field positions, reset values and codes for the output select block
`ifndef ROSEL_CONSTS_VH
`define ROSEL_CONSTS_VH

`define ROSEL_NCH            4
`define ROSEL_SMBUS_ADDR     7'h18

`define ROSEL_REG_STATUS     8'h01
`define ROSEL_REG_OVR        8'h09
`define ROSEL_REG_SDF        8'h14
`define ROSEL_REG_DIV        8'h18
`define ROSEL_REG_OSEL       8'h1e
`define ROSEL_REG_PAGE       8'hff

`define ROSEL_OVR_DIV_BIT    2
`define ROSEL_OVR_QCLK_BIT   4
`define ROSEL_OVR_MUX_BIT    5
`define ROSEL_SDF_OFF_BIT    6
`define ROSEL_SDF_ON_BIT     7
`define ROSEL_DIV_LSB        4
`define ROSEL_OSEL_QCLK_BIT  0
`define ROSEL_OSEL_PRBS_BIT  4
`define ROSEL_OSEL_LSB       5

`define ROSEL_OVR_RST        8'h00
`define ROSEL_SDF_RST        8'h00
`define ROSEL_DIV_RST        8'h00
`define ROSEL_OSEL_RST       8'he0
`define ROSEL_PAGE_RST       2'h0

`define ROSEL_SRC_RAW        3'h0
`define ROSEL_SRC_RETIMED    3'h1
`define ROSEL_SRC_ICLK       3'h2
`define ROSEL_SRC_QCLK       3'h3
`define ROSEL_SRC_PRBS       3'h4
`define ROSEL_SRC_OSC10M     3'h5
`define ROSEL_SRC_INVALID    3'h6
`define ROSEL_SRC_MUTE       3'h7

`define ROSEL_DIV_MAX        3'h4

`endif

// [design/rosel_smbus.v]
// smbus slave: byte writes and reads with a register pointer that auto-increments
`timescale 1ns/1ps
`include "rosel_consts.vh"
module rosel_smbus
(
   input  wire       clk_i,
   input  wire       nrst_i,
   input  wire       scl_i,
   input  wire       sda_i,
   output reg        sda_o,
   output reg        sda_oe_o,
   output reg  [7:0] addr_o,
   output reg  [7:0] wdata_o,
   output reg        wr_stb_o,
   input  wire [7:0] rdata_i
);
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_REG  = 3'd2;
   localparam ST_WR   = 3'd3;
   localparam ST_RD   = 3'd4;
   localparam ST_RACK = 3'd5;

   reg [2:0] state;
   reg [1:0] scl_sync;
   reg [1:0] sda_sync;
   reg       scl_d;
   reg       sda_d;
   reg [3:0] cnt;
   reg [7:0] sh;
   reg       ack;
   reg       rw;

   wire scl_s     = scl_sync[1];
   wire sda_s     = sda_sync[1];
   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire start_det = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;

   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end
      else
      begin
         scl_sync <= {scl_sync[0], scl_i};
         sda_sync <= {sda_sync[0], sda_i};
         scl_d    <= scl_s;
         sda_d    <= sda_s;
      end
   end

   // data changes only on falling scl so it is stable while scl is high
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state    <= ST_IDLE;
         cnt      <= 4'h0;
         sh       <= 8'h00;
         ack      <= 1'b0;
         rw       <= 1'b0;
         sda_o    <= 1'b0;
         sda_oe_o <= 1'b0;
         addr_o   <= 8'h00;
         wdata_o  <= 8'h00;
         wr_stb_o <= 1'b0;
      end
      else
      begin
         wr_stb_o <= 1'b0;
         if (start_det)
         begin
            state    <= ST_ADDR;
            cnt      <= 4'h0;
            ack      <= 1'b0;
            sda_oe_o <= 1'b0;
         end
         else if (stop_det)
         begin
            state    <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end
         else if (scl_rise && state != ST_IDLE)
         begin
            if (state == ST_RACK)
            begin
               if (sda_s)
                  state <= ST_IDLE;
               else
               begin
                  // master wants more: restart from the advanced pointer
                  state <= ST_RD;
                  cnt   <= 4'h0;
                  sh    <= rdata_i;
               end
            end
            else if (!ack)
            begin
               sh  <= {sh[6:0], sda_s};
               cnt <= cnt + 4'h1;
            end
         end
         else if (scl_fall && state != ST_IDLE)
         begin
            if (ack)
            begin
               ack      <= 1'b0;
               sda_oe_o <= 1'b0;
               cnt      <= 4'h0;
               if (state == ST_ADDR)
               begin
                  if (rw)
                  begin
                     state    <= ST_RD;
                     sh       <= rdata_i;
                     sda_oe_o <= ~rdata_i[7];
                  end
                  else
                     state <= ST_REG;
               end
               else if (state == ST_REG)
                  state <= ST_WR;
            end
            else if (state == ST_RD)
            begin
               if (cnt == 4'h8)
               begin
                  sda_oe_o <= 1'b0;
                  addr_o   <= addr_o + 8'h01;
                  state    <= ST_RACK;
               end
               else
                  // the byte shifts left on every rise, so the next bit is always on top
                  sda_oe_o <= ~sh[7];
            end
            else if (state == ST_RACK)
               sda_oe_o <= 1'b0;
            else if (cnt == 4'h8)
            begin
               if (state == ST_ADDR)
               begin
                  if (sh[7:1] == `ROSEL_SMBUS_ADDR)
                  begin
                     ack      <= 1'b1;
                     sda_oe_o <= 1'b1;
                     rw       <= sh[0];
                  end
                  else
                     state <= ST_IDLE;
               end
               else if (state == ST_REG)
               begin
                  ack      <= 1'b1;
                  sda_oe_o <= 1'b1;
                  addr_o   <= sh;
               end
               else
               begin
                  ack      <= 1'b1;
                  sda_oe_o <= 1'b1;
                  wdata_o  <= sh;
                  wr_stb_o <= 1'b1;
               end
            end
         end
         else if (state == ST_WR && wr_stb_o)
            addr_o <= addr_o + 8'h01;
      end
   end
endmodule // rosel_smbus

// [design/rosel_top.v]
// four-channel output source select, signal detect force and vco divider override
`timescale 1ns/1ps
`include "rosel_consts.vh"
// Overview of operation
// - no detect and no force: channel off, muted
// - unlocked, no override: drive selected source
// - locked, no override: drive retimed data
// - select codes: raw..osc, 6 invalid, 7 mute
// - override bit: drive selected source, even when locked
// - sdf bit7 set, bit6 clear forces detect
// - both sdf bits clear: automatic detect
// - 10 MHz oscillator selectable under override
// - clocks follow input when detected and locked, else free
// - automatic divider from detected bit rate
// - divider override bit uses field 6:4
// - divider field 0..4 maps to 1..16
// - override register resets to zero, zero clears
module rosel_top
(
   input  wire        clk_i,
   input  wire        nrst_i,
   input  wire        scl_i,
   input  wire        sda_i,
   output wire        sda_o,
   output wire        sda_oe_o,
   input  wire [3:0]  sig_det_i,
   input  wire [3:0]  lock_i,
   input  wire [11:0] auto_div_i,
   output reg  [3:0]  chan_pwr_en_o,
   output reg  [11:0] out_sel_o,
   output reg  [11:0] vco_div_o,
   output reg  [3:0]  qclk_en_o,
   output reg  [3:0]  prbs_en_o,
   output reg  [3:0]  vco_free_run_o
);
   wire [7:0]  bus_addr;
   wire [7:0]  bus_wdata;
   wire        bus_wr;
   reg  [7:0]  rdata;
   reg  [1:0]  page;
   reg  [3:0]  sd_meta;
   reg  [3:0]  sd_sync;
   reg  [3:0]  lk_meta;
   reg  [3:0]  lk_sync;
   reg  [7:0]  ovr_r  [0:3];
   reg  [7:0]  sdf_r  [0:3];
   reg  [7:0]  div_r  [0:3];
   reg  [7:0]  osel_r [0:3];
   wire [3:0]  next_pwr;
   wire [11:0] next_sel;
   wire [11:0] next_div;
   wire [3:0]  next_qclk;
   wire [3:0]  next_prbs;
   wire [3:0]  next_free;
   wire [7:0]  status_byte;
   integer     i;

   rosel_smbus rosel_smbus_inst
   (
      .clk_i    (clk_i),
      .nrst_i   (nrst_i),
      .scl_i    (scl_i),
      .sda_i    (sda_i),
      .sda_o    (sda_o),
      .sda_oe_o (sda_oe_o),
      .addr_o   (bus_addr),
      .wdata_o  (bus_wdata),
      .wr_stb_o (bus_wr),
      .rdata_i  (rdata)
   );

   // analog status arrives asynchronously
   // detect and lock take the same two stages so they arrive in step
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sd_meta <= 4'h0;
         sd_sync <= 4'h0;
         lk_meta <= 4'h0;
         lk_sync <= 4'h0;
      end
      else
      begin
         sd_meta <= sig_det_i;
         sd_sync <= sd_meta;
         lk_meta <= lock_i;
         lk_sync <= lk_meta;
      end
   end

   // register file, one copy per channel, writes land on the paged channel
   // the page register is shared; writes to unmapped offsets are dropped
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         page <= `ROSEL_PAGE_RST;
         for (i = 0; i < `ROSEL_NCH; i = i + 1)
         begin
            ovr_r[i]  <= `ROSEL_OVR_RST;
            sdf_r[i]  <= `ROSEL_SDF_RST;
            div_r[i]  <= `ROSEL_DIV_RST;
            osel_r[i] <= `ROSEL_OSEL_RST;
         end
      end
      else if (bus_wr)
      begin
         if (bus_addr == `ROSEL_REG_PAGE)
            page <= bus_wdata[1:0];
         else if (bus_addr == `ROSEL_REG_OVR)
            ovr_r[page] <= bus_wdata;
         else if (bus_addr == `ROSEL_REG_SDF)
            sdf_r[page] <= bus_wdata;
         else if (bus_addr == `ROSEL_REG_DIV)
            div_r[page] <= bus_wdata;
         else if (bus_addr == `ROSEL_REG_OSEL)
            osel_r[page] <= bus_wdata;
      end
   end

   // status of the paged channel; bit 4 is spare and reads zero
   assign status_byte = {out_sel_o[page*3 +: 3], 1'b0, vco_div_o[page*3 +: 3] == 3'h0,
                         chan_pwr_en_o[page], lk_sync[page], sd_sync[page]};

   // read mux; unmapped offsets read as zero
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata <= 8'h00;
      else if (bus_addr == `ROSEL_REG_PAGE)
         rdata <= {6'h00, page};
      else if (bus_addr == `ROSEL_REG_OVR)
         rdata <= ovr_r[page];
      else if (bus_addr == `ROSEL_REG_SDF)
         rdata <= sdf_r[page];
      else if (bus_addr == `ROSEL_REG_DIV)
         rdata <= div_r[page];
      else if (bus_addr == `ROSEL_REG_OSEL)
         rdata <= osel_r[page];
      else if (bus_addr == `ROSEL_REG_STATUS)
         rdata <= status_byte;
      else
         rdata <= 8'h00;
   end

   // each channel decodes only its own copy; nothing is shared between them
   genvar g;
   generate
      for (g = 0; g < `ROSEL_NCH; g = g + 1)
      begin : ch
         wire       force_on  = sdf_r[g][`ROSEL_SDF_ON_BIT] & ~sdf_r[g][`ROSEL_SDF_OFF_BIT];
         wire       force_off = sdf_r[g][`ROSEL_SDF_OFF_BIT] & ~sdf_r[g][`ROSEL_SDF_ON_BIT];
         // with neither force pattern the detector rules alone
         wire       detect    = force_on | (sd_sync[g] & ~force_off);
         wire       mux_ovr   = ovr_r[g][`ROSEL_OVR_MUX_BIT];
         wire [2:0] field     = osel_r[g][`ROSEL_OSEL_LSB +: 3];
         // the unused code is parked on mute rather than an undefined source
         wire [2:0] field_ok  = (field == `ROSEL_SRC_INVALID) ? `ROSEL_SRC_MUTE : field;
         wire [2:0] ovr_div   = div_r[g][`ROSEL_DIV_LSB +: 3];
         reg  [2:0] sel;
         reg  [2:0] div;

         // priority: power first, then override, then lock, then the field
         always @*
         begin
            if (!detect)
               sel = `ROSEL_SRC_MUTE;
            else if (mux_ovr)
               sel = field_ok;
            else if (lk_sync[g])
               sel = `ROSEL_SRC_RETIMED;
            else
               sel = field_ok;
         end

         always @*
         begin
            if (ovr_r[g][`ROSEL_OVR_DIV_BIT])
               // out-of-range codes saturate to the largest ratio
               div = (ovr_div > `ROSEL_DIV_MAX) ? `ROSEL_DIV_MAX : ovr_div;
            else
               div = auto_div_i[g*3 +: 3];
         end

         assign next_pwr[g]       = detect;
         assign next_sel[g*3 +: 3] = sel;
         assign next_div[g*3 +: 3] = div;
         // quadrature clock runs only when both enables are set
         assign next_qclk[g]      = ovr_r[g][`ROSEL_OVR_QCLK_BIT] &
                                    osel_r[g][`ROSEL_OSEL_QCLK_BIT];
         // only the enable is kept here; the pattern logic sits outside
         assign next_prbs[g]      = osel_r[g][`ROSEL_OSEL_PRBS_BIT];
         assign next_free[g]      = ~(detect & lk_sync[g]);
      end
   endgenerate

   // pins see a detect or lock change three clocks after it arrives
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         chan_pwr_en_o  <= 4'h0;
         out_sel_o      <= 12'hfff;
         vco_div_o      <= 12'h000;
         qclk_en_o      <= 4'h0;
         prbs_en_o      <= 4'h0;
         vco_free_run_o <= 4'hf;
      end
      else
      begin
         chan_pwr_en_o  <= next_pwr;
         out_sel_o      <= next_sel;
         vco_div_o      <= next_div;
         qclk_en_o      <= next_qclk;
         prbs_en_o      <= next_prbs;
         vco_free_run_o <= next_free;
      end
   end
endmodule // rosel_top

// [tb/rosel_props.sv]
// port-level checks for the output select block
`timescale 1ns/1ps
module rosel_props
(
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_o,
   input wire logic [3:0]  lock_i,
   input wire logic [3:0]  chan_pwr_en_o,
   input wire logic [11:0] out_sel_o,
   input wire logic [11:0] vco_div_o,
   input wire logic [3:0]  qclk_en_o,
   input wire logic [3:0]  prbs_en_o,
   input wire logic [3:0]  vco_free_run_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_reset_src_div: assert property ($rose(nrst_i) |-> out_sel_o == 12'hfff
      && vco_div_o == 12'h000)
      else $error("source or divider not at reset value");
   a_reset_enables: assert property ($rose(nrst_i) |-> !chan_pwr_en_o && !qclk_en_o
      && !prbs_en_o && vco_free_run_o == 4'hf)
      else $error("enables not at reset value");
   a_sda_released: assert property ($rose(nrst_i) |-> !sda_oe_o && !sda_o)
      else $error("data line held after reset");
   for (genvar c = 0; c < 4; c++)
   begin : g_ch
      a_mute_unpowered: assert property (!chan_pwr_en_o[c] |-> out_sel_o[3*c+:3] == 3'h7)
         else $error("unpowered channel not muted");
      a_no_invalid_src: assert property (out_sel_o[3*c+:3] != 3'h6)
         else $error("invalid source driven");
      a_div_in_range: assert property (vco_div_o[3*c+:3] <= 3'h4)
         else $error("divider code out of range");
      a_free_unlocked: assert property ((!lock_i[c]) [*5] |-> vco_free_run_o[c])
         else $error("vco not free running without lock");
      a_locked_powered: assert property (!vco_free_run_o[c] |-> chan_pwr_en_o[c])
         else $error("vco follows input on unpowered channel");
   end
endmodule // rosel_props
bind rosel_top rosel_props rosel_props_inst (.clk_i(clk_i), .nrst_i(nrst_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .lock_i(lock_i), .chan_pwr_en_o(chan_pwr_en_o), .out_sel_o(out_sel_o),
   .vco_div_o(vco_div_o), .qclk_en_o(qclk_en_o), .prbs_en_o(prbs_en_o),
   .vco_free_run_o(vco_free_run_o));

// [tb/rosel_host.sv]
// smbus host model that writes and reads the channel registers
`timescale 1ns/1ps
`include "rosel_consts.vh"
module rosel_host
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task hp(input integer n);
      repeat (n) @(negedge clk_i);
   endtask
   // data moves mid-way through scl low so it is never taken for a start or stop
   task bitx(input logic b, output logic r);
      hp(6);
      sda_low_o = !b;
      hp(6);
      scl_o = 1'b1;
      hp(12);
      r = sda_i;
      scl_o = 1'b0;
   endtask
   task tx(input [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   task rx(output [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(1'b1, d[i]);
      bitx(1'b1, r);
   endtask
   task start;
      hp(6);
      sda_low_o = 1'b0;
      hp(6);
      scl_o = 1'b1;
      hp(12);
      sda_low_o = 1'b1;
      hp(12);
      scl_o = 1'b0;
   endtask
   task stop;
      hp(6);
      sda_low_o = 1'b1;
      hp(6);
      scl_o = 1'b1;
      hp(12);
      sda_low_o = 1'b0;
      hp(12);
   endtask
   task wr(input [7:0] a, input [7:0] d, output logic nak);
      logic k0, k1, k2;
      start;
      tx({`ROSEL_SMBUS_ADDR, 1'b0}, k0);
      tx(a, k1);
      tx(d, k2);
      stop;
      nak = !(k0 && k1 && k2);
   endtask
   task rd(input [7:0] a, output [7:0] d, output logic nak);
      logic k0, k1, k2;
      start;
      tx({`ROSEL_SMBUS_ADDR, 1'b0}, k0);
      tx(a, k1);
      start;
      tx({`ROSEL_SMBUS_ADDR, 1'b1}, k2);
      rx(d);
      stop;
      nak = !(k0 && k1 && k2);
   endtask
endmodule // rosel_host

// [tb/test_retimer_output_select_override.sv]
// self-checking bench for the output select block
`timescale 1ns/1ps
`include "rosel_consts.vh"
`define CMP(n, e, g) begin cmp_count++; if ((e) !== (g)) begin err_count++; \
   $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module test_retimer_output_select_override;
   logic        clk_i = 0;
   logic        nrst_i = 0;
   logic [3:0]  sig_det_i = 0;
   logic [3:0]  lock_i = 0;
   logic [11:0] auto_div_i = 0;
   wire         scl, sda_low, sda_oe, sda_o;
   wire  [3:0]  pwr, qen, pen, frun;
   wire  [11:0] osel, vdiv;
   wire         sda = !(sda_low || sda_oe);
   integer      err_count = 0, cmp_count = 0, seed = 41;
   logic [11:0] exp_q[$], ov, ev;
   string       on;
   event        oe;
   always #2 clk_i = !clk_i;
   rosel_top rosel_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .sig_det_i(sig_det_i), .lock_i(lock_i),
      .auto_div_i(auto_div_i), .chan_pwr_en_o(pwr), .out_sel_o(osel), .vco_div_o(vdiv),
      .qclk_en_o(qen), .prbs_en_o(pen), .vco_free_run_o(frun));
   rosel_host rosel_host_inst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
   task summarize;
      $display("TB: %0d mismatches in %0d comparisons", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // the note goes on the queue; the watcher below pops and compares it
   task chk(input string n, input [11:0] e, input [11:0] v);
      exp_q.push_back(e);
      on = n;
      ov = v;
      ->oe;
      #1;
   endtask
   always
   begin
      @(oe);
      ev = exp_q.pop_front();
      `CMP(on, ev, ov)
   end
   task w(input [7:0] a, input [7:0] d);
      logic n;
      rosel_host_inst.wr(a, d, n);
      chk("write ack", 0, n);
   endtask
   task r(input [7:0] a, input [7:0] e);
      logic [7:0] d;
      logic n;
      rosel_host_inst.rd(a, d, n);
      chk("read data", {1'b0, e}, {n, d});
   endtask
   task inp(input [3:0] s, input [3:0] l);
      @(negedge clk_i);
      sig_det_i = s;
      lock_i = l;
      repeat (8) @(negedge clk_i);
   endtask
   initial
   begin
      repeat (100000) @(posedge clk_i);
      err_count++;
      summarize;
   end
   initial
   begin
      repeat (6) @(negedge clk_i);
      nrst_i = 1;
      inp(0, 0);
      chk("osel", 12'hfff, osel);
      r(`ROSEL_REG_OVR, 8'h00);
      r(`ROSEL_REG_SDF, 8'h00);
      r(`ROSEL_REG_DIV, 8'h00);
      r(`ROSEL_REG_OSEL, 8'he0);
      r(8'h30, 8'h00);
      chk("pwr", 0, pwr[0]);
      $display("TB: reset and idle done");
      inp(1, 0);
      for (int k = 0; k < 8; k++)
      begin
         w(`ROSEL_REG_OSEL, 8'(k << 5));
         chk("osel", (k == 6) ? 7 : k, osel[2:0]);
      end
      inp(1, 1);
      chk("osel", 1, osel[2:0]);
      chk("frun", 0, frun[0]);
      w(`ROSEL_REG_OVR, 8'h20);
      w(`ROSEL_REG_OSEL, 8'ha0);
      chk("osel", 5, osel[2:0]);
      $display("TB: source select done");
      inp(0, 0);
      w(`ROSEL_REG_SDF, 8'h80);
      chk("pwr", 1, pwr[0]);
      chk("osel", 5, osel[2:0]);
      chk("frun", 1, frun[0]);
      w(`ROSEL_REG_OVR, 8'h30);
      w(`ROSEL_REG_OSEL, 8'h71);
      chk("osel qen pen", 5'h0f, {osel[2:0], qen[0], pen[0]});
      w(`ROSEL_REG_SDF, 8'h00);
      chk("pwr osel", 4'h7, {pwr[0], osel[2:0]});
      $display("TB: detect force done");
      @(negedge clk_i);
      for (int c = 0; c < 4; c++)
         auto_div_i[3*c+:3] = 3'({$random(seed)} % 5);
      inp(1, 0);
      chk("vdiv", auto_div_i, vdiv);
      w(`ROSEL_REG_OVR, 8'h04);
      for (int k = 0; k < 5; k++)
      begin
         w(`ROSEL_REG_DIV, 8'(k << 4));
         chk("vdiv", k, vdiv[2:0]);
      end
      w(`ROSEL_REG_OVR, 8'h00);
      chk("vdiv", auto_div_i, vdiv);
      $display("TB: divider done");
      inp(3, 0);
      w(`ROSEL_REG_PAGE, 8'h01);
      w(`ROSEL_REG_OSEL, 8'h00);
      chk("osel", 6'h03, osel[5:0]);
      w(`ROSEL_REG_PAGE, 8'h00);
      r(`ROSEL_REG_OSEL, 8'h71);
      inp(3, 1);
      chk("osel", 1, osel[2:0]);
      w(`ROSEL_REG_SDF, 8'h40);
      chk("pwr osel", 4'h7, {pwr[0], osel[2:0]});
      w(`ROSEL_REG_SDF, 8'hc0);
      chk("pwr osel", 4'h9, {pwr[0], osel[2:0]});
      r(`ROSEL_REG_STATUS, {3'h1, 1'b0, auto_div_i[2:0] == 3'h0, 3'h7});
      $display("TB: channel pages done");
      summarize;
   end
endmodule // test_retimer_output_select_override
